// [logic/pbc_pkg.sv]
// pbc_pkg: constants and carrier types for one port-bypass channel.
// assumes a 50 MHz core clock shared by every user of the package.
package pbc_pkg;

    // register position in the device map and bit layout
    localparam logic [7:0] REG_ADDR      = 8'h28;
    localparam int         BIT_EN        = 7;
    localparam int         BIT_IRQ_EN    = 6;
    localparam int         BIT_FB        = 1;
    localparam int         BIT_SD        = 0;

    // values after reset: channel and interrupt off, force-bypass bit set
    localparam logic       RST_EN        = 1'b0;
    localparam logic       RST_IRQ_EN    = 1'b0;
    localparam logic       RST_FB        = 1'b1;
    localparam logic [7:0] RST_IRQ_SRC   = 8'h00;

    // timing
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         LOSS_MAX_NS   = 400;
    localparam int         LOSS_MAX_CYC  = LOSS_MAX_NS / CLK_PERIOD_NS;
    localparam int         FILT_CYC      = 3;
    localparam logic [1:0] FILT_LAST     = 2'(FILT_CYC - 1);

    // one pad: driven value and active-low output enable
    typedef struct packed {
        logic val;
        logic oe_n;
    } pbc_pin_t;

    // software-written control bits of the channel register
    typedef struct packed {
        logic en;
        logic irq_en;
        logic fb;
    } pbc_ctl_t;

endpackage : pbc_pkg

// [logic/pbc_sync_filter.sv]
// pbc_sync_filter: two-flop synchroniser followed by a stability filter.
// assumes an asynchronous pad input; output changes only after FILT_CYC equal samples.
`timescale 1ns/100ps
`default_nettype none

module pbc_sync_filter (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic raw_in,
    output var  logic level_out
);

    logic       meta_q;
    logic       sync_q;
    logic [1:0] cnt_q;
    logic       level_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // pads power up pulled high, so the filter starts at 1
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q   <= 2'h0;
            level_q <= 1'b1;
        end else if (sync_q == level_q) begin
            cnt_q   <= 2'h0;
        end else if (cnt_q == pbc_pkg::FILT_LAST) begin
            cnt_q   <= 2'h0;
            level_q <= sync_q;
        end else begin
            cnt_q   <= cnt_q + 2'h1;
        end
    end

    assign level_out = level_q;

endmodule : pbc_sync_filter
`default_nettype wire

// [logic/pbc_channel.sv]
// pbc_channel: control register and pin logic of one port-bypass channel.
// assumes the serial slave core presents one-cycle write strobes for this register
// and pulses irq_ack_in when the shared interrupt source register is read.
`timescale 1ns/100ps
`default_nettype none

module pbc_channel (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             reg_wr_in,
    input  wire logic [7:0]       reg_wdata_in,
    output var  logic [7:0]       reg_rdata_out,
    input  wire logic             irq_ack_in,
    output var  logic             irq_n_out,
    output var  logic [7:0]       irq_source_index_out,
    input  wire pbc_pkg::pbc_pin_t gpio_drive_cfg_in,
    input  wire pbc_pkg::pbc_pin_t gpio_sense_cfg_in,
    output var  pbc_pkg::pbc_pin_t bypass_drive_pin_out,
    output var  pbc_pkg::pbc_pin_t sigdet_sense_pin_out,
    input  wire logic             bypass_drive_pin_in,
    input  wire logic             sigdet_sense_pin_in
);

    pbc_pkg::pbc_ctl_t ctl_q;
    logic              sd_filt;
    logic              drive_filt;
    logic              sd_prev_q;
    logic              sd_edge;
    logic              irq_event;
    logic              irq_n_q;
    logic [7:0]        irq_src_q;
    logic [7:0]        rdata_d;
    logic [7:0]        rdata_q;
    pbc_pkg::pbc_pin_t drive_q;
    pbc_pkg::pbc_pin_t sense_q;

    // each pad is read through its own instance of the synchroniser and filter
    pbc_sync_filter u_sense_filt (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .raw_in    (sigdet_sense_pin_in),
        .level_out (sd_filt)
    );

    pbc_sync_filter u_drive_filt (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .raw_in    (bypass_drive_pin_in),
        .level_out (drive_filt)
    );

    // hardware clear beats a software write: a write cannot re-arm normal
    // mode while the link is down
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl_q.en     <= pbc_pkg::RST_EN;
            ctl_q.irq_en <= pbc_pkg::RST_IRQ_EN;
            ctl_q.fb     <= pbc_pkg::RST_FB;
        end else begin
            if (reg_wr_in) begin
                ctl_q.en     <= reg_wdata_in[pbc_pkg::BIT_EN];
                ctl_q.irq_en <= reg_wdata_in[pbc_pkg::BIT_IRQ_EN];
            end
            if (!sd_filt) begin
                ctl_q.fb <= 1'b0;
            end else if (reg_wr_in) begin
                ctl_q.fb <= reg_wdata_in[pbc_pkg::BIT_FB];
            end
        end
    end

    // transitions are taken from the filtered level so glitches never interrupt
    assign sd_edge   = sd_filt ^ sd_prev_q;
    assign irq_event = sd_edge && ctl_q.irq_en;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sd_prev_q <= 1'b1;
        end else begin
            sd_prev_q <= sd_filt;
        end
    end

    // event wins over an acknowledge in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_n_q   <= 1'b1;
            irq_src_q <= pbc_pkg::RST_IRQ_SRC;
        end else if (irq_event) begin
            irq_n_q   <= 1'b0;
            irq_src_q <= pbc_pkg::REG_ADDR;
        end else if (irq_ack_in) begin
            irq_n_q   <= 1'b1;
        end
    end

    // enabled: push-pull drive of the force-bypass bit, sense pad as input;
    // disabled: the pads follow whatever the general-purpose logic asks
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drive_q <= '{val: 1'b1, oe_n: 1'b1};
            sense_q <= '{val: 1'b1, oe_n: 1'b1};
        end else if (ctl_q.en) begin
            drive_q <= '{val: ctl_q.fb, oe_n: 1'b0};
            sense_q <= '{val: 1'b1, oe_n: 1'b1};
        end else begin
            drive_q <= gpio_drive_cfg_in;
            sense_q <= gpio_sense_cfg_in;
        end
    end

    // bit 0 always reads back the filtered sense level; bit 1 shows the filtered drive pad when disabled, the fb bit when enabled
    always_comb begin
        rdata_d                     = 8'h00;
        rdata_d[pbc_pkg::BIT_EN]     = ctl_q.en;
        rdata_d[pbc_pkg::BIT_IRQ_EN] = ctl_q.irq_en;
        rdata_d[pbc_pkg::BIT_FB]     = ctl_q.en ? ctl_q.fb : drive_filt;
        rdata_d[pbc_pkg::BIT_SD]     = sd_filt;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out        = rdata_q;
    assign irq_n_out            = irq_n_q;
    assign irq_source_index_out = irq_src_q;
    assign bypass_drive_pin_out = drive_q;
    assign sigdet_sense_pin_out = sense_q;

    // helper: cycles the pad has been low while the channel still drives normal mode
    int loss_cnt_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            loss_cnt_q <= 0;
        end else if (ctl_q.en && !sigdet_sense_pin_in && drive_q.val && !drive_q.oe_n) begin
            loss_cnt_q <= loss_cnt_q + 1;
        end else begin
            loss_cnt_q <= 0;
        end
    end

    property p_loss_bound;
        @(posedge clk_in) disable iff (!nrst_in)
        loss_cnt_q < pbc_pkg::LOSS_MAX_CYC;
    endproperty
    a_loss_bound: assert property (p_loss_bound) else $error("bypass drive not released in time");

    property p_fb_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        !sd_filt |=> !ctl_q.fb;
    endproperty
    a_fb_clear: assert property (p_fb_clear) else $error("force-bypass bit kept while sense low");

    property p_drive_low;
        @(posedge clk_in) disable iff (!nrst_in)
        !sd_filt ##1 ctl_q.en |=> (!drive_q.val && !drive_q.oe_n);
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("drive pin not low after loss");

    property p_drive_follow;
        @(posedge clk_in) disable iff (!nrst_in)
        ctl_q.en |=> (!drive_q.oe_n && drive_q.val == $past(ctl_q.fb) && sense_q.oe_n);
    endproperty
    a_drive_follow: assert property (p_drive_follow) else $error("drive pin not following bit");

    property p_disabled_pass;
        @(posedge clk_in) disable iff (!nrst_in)
        // the edge that releases reset still loads reset values, so start one edge later
        nrst_in && !ctl_q.en |=> (drive_q == $past(gpio_drive_cfg_in) && sense_q == $past(gpio_sense_cfg_in));
    endproperty
    a_disabled_pass: assert property (p_disabled_pass) else $error("pins touched while disabled");

    property p_irq_raise;
        @(posedge clk_in) disable iff (!nrst_in)
        (sd_filt != sd_prev_q) && ctl_q.irq_en |=> (!irq_n_out && irq_source_index_out == pbc_pkg::REG_ADDR);
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised on transition");

    property p_irq_quiet;
        @(posedge clk_in) disable iff (!nrst_in)
        irq_n_out && (!ctl_q.irq_en || sd_filt == sd_prev_q) |=> irq_n_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled transition");

    property p_sd_read;
        @(posedge clk_in) disable iff (!nrst_in)
        nrst_in |=> reg_rdata_out[pbc_pkg::BIT_SD] == $past(sd_filt);
    endproperty
    a_sd_read: assert property (p_sd_read) else $error("status bit not filtered pin level");

    property p_sense_sync;
        @(posedge clk_in) disable iff (!nrst_in)
        $changed(sd_filt) |-> $past(sigdet_sense_pin_in, 3) == sd_filt;
    endproperty
    a_sense_sync: assert property (p_sense_sync) else $error("sense level changed without filtering");

    c_loss: cover property (@(posedge clk_in) disable iff (!nrst_in)
        ctl_q.en && ctl_q.fb ##1 !sd_filt ##2 !drive_q.val);
    c_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(sd_filt) && ctl_q.irq_en ##1 !irq_n_out);
    c_ack_race: cover property (@(posedge clk_in) disable iff (!nrst_in)
        irq_ack_in && irq_event);

endmodule : pbc_channel
`default_nettype wire

// [verification/pbc_far_side.sv]
// pbc_far_side: external bypass circuit and board pads facing one channel.
// assumes the pad structs from pbc_pkg; a released drive pad shows a pull level and a released sense pad the detector output, not the last value.
`timescale 1ns/100ps
`default_nettype none

module pbc_far_side (
    input  wire pbc_pkg::pbc_pin_t drive_pin_in,
    input  wire pbc_pkg::pbc_pin_t sense_pin_in,
    input  wire logic              signal_on_in,
    input  wire logic              pull_dn_in,
    output var  logic              drive_pad_out,
    output var  logic              sense_pad_out,
    output var  logic              bypass_mode_out
);
    // a released drive pad sits on the weak pull-up unless the board fits a pull-down
    assign drive_pad_out   = drive_pin_in.oe_n ? ~pull_dn_in : drive_pin_in.val;
    // detector output is high while a high-speed signal is present
    assign sense_pad_out   = sense_pin_in.oe_n ? signal_on_in : sense_pin_in.val;
    // low drive level forces the loop into bypass
    assign bypass_mode_out = ~drive_pad_out;
endmodule : pbc_far_side

`default_nettype wire

// [verification/tb_top.sv]
// tb_top: self-checking bench for one port-bypass channel.
// assumes pbc_far_side stands for the external bypass circuit and its pads.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic              clk_in, nrst_in, reg_wr_in, irq_ack_in, signal_on, pull_dn;
    logic [7:0]        reg_wdata_in, reg_rdata_out, irq_source_index_out;
    logic              irq_n_out, drive_pad, sense_pad, bypass_mode;
    pbc_pkg::pbc_pin_t gpio_drive_cfg_in, gpio_sense_cfg_in, drive_out, sense_out;
    int                bad_count, num_checks, n;

    pbc_channel dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .irq_ack_in(irq_ack_in), .irq_n_out(irq_n_out),
        .irq_source_index_out(irq_source_index_out), .gpio_drive_cfg_in(gpio_drive_cfg_in),
        .gpio_sense_cfg_in(gpio_sense_cfg_in), .bypass_drive_pin_out(drive_out),
        .sigdet_sense_pin_out(sense_out), .bypass_drive_pin_in(drive_pad), .sigdet_sense_pin_in(sense_pad));
    pbc_far_side far (.drive_pin_in(drive_out), .sense_pin_in(sense_out), .signal_on_in(signal_on),
        .pull_dn_in(pull_dn), .drive_pad_out(drive_pad), .sense_pad_out(sense_pad), .bypass_mode_out(bypass_mode));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
        tick(2);
    endtask : wr

    task automatic ack;
        @(posedge clk_in);
        irq_ack_in <= 1'b1;
        @(posedge clk_in);
        irq_ack_in <= 1'b0;
        tick(1);
        chk("irq_n after ack", {7'h00, irq_n_out}, 8'h01);
    endtask : ack

    task automatic t_reset;
        tick(10);
        chk("rdata pad driven low", reg_rdata_out, 8'h01);
        chk("drive pin gpio", {6'h00, drive_out}, 8'h00);
        @(posedge clk_in);
        gpio_drive_cfg_in <= '{val: 1'b1, oe_n: 1'b1};
        gpio_sense_cfg_in <= '{val: 1'b1, oe_n: 1'b0};
        tick(10);
        chk("rdata pull default", reg_rdata_out, 8'h03);
        chk("sense pin gpio", {6'h00, sense_out}, 8'h02);
        chk("irq_n idle", {7'h00, irq_n_out}, 8'h01);
    endtask : t_reset

    task automatic t_enable;
        // read default, write it back, then enable
        wr(8'h02);
        chk("drive pin still gpio", {6'h00, drive_out}, 8'h03);
        chk("sense pin still gpio", {6'h00, sense_out}, 8'h02);
        wr(8'h82);
        chk("rdata enabled", reg_rdata_out, 8'h83);
        chk("drive pin normal", {6'h00, drive_out}, 8'h02);
        chk("sense pin input", {7'h00, sense_out.oe_n}, 8'h01);
        chk("far side normal", {7'h00, bypass_mode}, 8'h00);
    endtask : t_enable

    task automatic t_force;
        // reserved bits and the status bit ignore writes
        wr(8'hBD);
        chk("rdata forced", reg_rdata_out, 8'h81);
        chk("drive pin bypass", {6'h00, drive_out}, 8'h00);
        chk("far side bypass", {7'h00, bypass_mode}, 8'h01);
        wr(8'hC2);
        chk("rdata irq on", reg_rdata_out, 8'hC3);
    endtask : t_force

    task automatic t_loss;
        @(posedge clk_in);
        signal_on <= 1'b0;
        n = 0;
        while (drive_out.val !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
        chk("loss latency ok", {7'h00, n <= pbc_pkg::LOSS_MAX_CYC}, 8'h01);
        tick(2);
        chk("irq_n on loss", {7'h00, irq_n_out}, 8'h00);
        chk("irq source", irq_source_index_out, pbc_pkg::REG_ADDR);
        chk("rdata cleared", reg_rdata_out, 8'hC0);
        wr(8'hC2);
        chk("rdata write while low", reg_rdata_out, 8'hC0);
        ack();
        @(posedge clk_in);
        signal_on <= 1'b1;
        tick(10);
        chk("irq_n on rise", {7'h00, irq_n_out}, 8'h00);
        chk("rdata back", reg_rdata_out, 8'hC1);
        ack();
    endtask : t_loss

    task automatic t_quiet;
        wr(8'h82);
        @(posedge clk_in);
        signal_on <= 1'b0;
        @(posedge clk_in);
        signal_on <= 1'b1;
        tick(10);
        chk("glitch filtered", reg_rdata_out, 8'h83);
        @(posedge clk_in);
        signal_on <= 1'b0;
        tick(10);
        chk("rdata quiet loss", reg_rdata_out, 8'h80);
        @(posedge clk_in);
        signal_on <= 1'b1;
        tick(10);
        chk("irq_n quiet", {7'h00, irq_n_out}, 8'h01);
    endtask : t_quiet

    task automatic conclude;
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    initial begin
        #60000;
        bad_count++;
        conclude();
    end

    initial begin
        nrst_in           = 1'b0;
        reg_wr_in         = 1'b0;
        reg_wdata_in      = 8'h00;
        irq_ack_in        = 1'b0;
        signal_on         = 1'b1;
        pull_dn           = 1'b0;
        gpio_drive_cfg_in = '{val: 1'b0, oe_n: 1'b0};
        gpio_sense_cfg_in = '{val: 1'b1, oe_n: 1'b1};
        bad_count         = 0;
        num_checks        = 0;
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_enable();
        t_force();
        t_loss();
        t_quiet();
        conclude();
    end
endmodule : tb_top

`default_nettype wire
